// [hdl/io_master_regs.svh]
// Purpose: Constants for the I/O master bus access and addressing block
// Assumes: 16-bit backplane data path, six-bit select code field
// Notes:   Timing counts are in memory cycles, not clock cycles
`ifndef IO_MASTER_REGS_SVH
`define IO_MASTER_REGS_SVH

`define DATA_WIDTH        16
`define SEL_WIDTH         6
`define SEL_LSB           0
`define OPC_WIDTH         10
`define CPU_STARVE_LIMIT  33
`define CNT_WIDTH         16
`define FIFO_DEPTH        32
`define SELECT_RESET      6'h00

`endif

// [hdl/io_master_pkg.sv]
// Purpose: Types shared by the I/O master block
// Assumes: Constants header supplies widths
// Notes:   Instruction word splits into opcode and select or spare field
`include "io_master_regs.svh"

package io_master_pkg;

	typedef enum logic [1:0] {
		IOI_NONE,
		IOI_ADDRESS,
		IOI_TRANSFER
	} io_kind_type;

	typedef struct packed {
		logic [`OPC_WIDTH-1:0] opcode;
		logic [`SEL_WIDTH-1:0] field;
	} io_instr_type;

	typedef struct packed {
		logic                   valid;
		logic [`DATA_WIDTH-1:0] addr;
		logic [`DATA_WIDTH-1:0] count;
	} dma_desc_type;

endpackage : io_master_pkg

// [hdl/data_fifo.sv]
// Purpose: Width and depth parameterised FIFO with valid and ready
// Assumes: Single clock, power-of-two depth
// Notes:   Pointers carry a wrap bit for honest full and empty
`timescale 1ns/10ps

module data_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_r;
	logic [AW:0]      rd_ptr_r;
	logic             push;
	logic             pop;

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("data_fifo depth must be a power of two");
	end

	assign in_ready  = !((wr_ptr_r[AW] != rd_ptr_r[AW]) &&
	                     (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
	assign out_valid = (wr_ptr_r != rd_ptr_r);
	assign out_data  = mem[rd_ptr_r[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge mclk) begin
		if (push)
			mem[wr_ptr_r[AW-1:0]] <= in_data;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end

endmodule : data_fifo

// [hdl/io_master.sv]
// Purpose: Per-card I/O master: DMA engine, priority chain, CPU fairness, addressing
// Assumes: Backplane signals arrive from other cards and pass two flip-flops
// Notes:   Contract
// Contract
// - Card runs its own DMA; chain interrupts CPU once at end.
// - End-of-transfer input stops the active DMA immediately; code sees it two flops late and still writes the word won that cycle.
// - Every card may master memory by DMA; no count limit.
// - Priority follows chain position; upstream card wins.
// - CPU gets memory in any cycle no card uses.
// - Under continuous I/O use CPU gets the 33rd cycle after request.
// - A bypassed slot passes the priority grant straight through; code passes it three flops late (two sync flops, one output flop).
// - Address match uses a select code, not the slot position.
// - Compatibility mode: respond only to matching select code.
// - Auto mode: an addressing instruction latches selection.
// - Auto mode selected: ignore select field of later instructions.
// - Auto mode: six freed bits go to the card.
// - All bus data is 16 bits wide.
`include "io_master_regs.svh"
`timescale 1ns/10ps

module io_master #(
	parameter int DATA_WIDTH = `DATA_WIDTH,
	parameter int STARVE     = `CPU_STARVE_LIMIT,
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	// Strap inputs
	input  wire logic [`SEL_WIDTH-1:0]   my_select,
	input  wire logic                    auto_mode,
	input  wire logic                    slot_bypass,
	// Instruction from CPU
	input  wire io_master_pkg::io_instr_type instr,
	input  wire io_master_pkg::io_kind_type  instr_kind,
	input  wire logic                    instr_strobe,
	output logic                         instr_accept,
	output logic [`SEL_WIDTH-1:0]        card_field,
	// DMA descriptor load and end-of-transfer
	input  wire io_master_pkg::dma_desc_type desc_in,
	input  wire logic                    desc_last,
	input  wire logic                    eot_in,
	// Device data
	input  wire logic [DATA_WIDTH-1:0]   dev_data,
	input  wire logic                    dev_valid,
	output logic                         dev_ready,
	// Backplane
	input  wire logic                    prio_in,
	output logic                         prio_out,
	input  wire logic                    cpu_req,
	output logic                         cpu_grant,
	output logic                         mem_req,
	output logic [DATA_WIDTH-1:0]        mem_addr,
	output logic [DATA_WIDTH-1:0]        mem_wdata,
	output logic                         mem_write,
	output logic                         chain_irq
);
	typedef enum {ST_IDLE, ST_RUN, ST_DONE} dma_state_type;

	initial begin
		if (DATA_WIDTH != `DATA_WIDTH)
			$error("io_master data width must be 16");
		if (STARVE < 2 || STARVE > 255)
			$error("io_master starvation limit out of range");
	end

	// Two-flop synchronisers for backplane and end-of-transfer pins
	logic [2:0] meta_r;
	logic [2:0] sync_r;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= {prio_in, cpu_req, eot_in};
			sync_r <= meta_r;
		end
	end
	logic prio_s;
	logic cpu_req_s;
	logic eot_s;
	assign {prio_s, cpu_req_s, eot_s} = sync_r;

	dma_state_type              state_r;
	logic [DATA_WIDTH-1:0]      addr_r;
	logic [DATA_WIDTH-1:0]      count_r;
	logic                       last_r;
	logic                       selected_r;
	logic [7:0]                 starve_r;
	logic [DATA_WIDTH-1:0]      fifo_data;
	logic                       fifo_valid;
	logic                       want_bus;
	logic                       cpu_turn;
	logic                       won_bus;
	logic                       addressed;

	data_fifo #(
		.WIDTH (DATA_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_data   (dev_data),
		.in_valid  (dev_valid),
		.in_ready  (dev_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (won_bus)
	);

	assign want_bus = (state_r == ST_RUN) && fifo_valid && !slot_bypass;
	assign cpu_turn = cpu_req_s && (starve_r >= 8'(STARVE - 1));
	assign won_bus  = want_bus && prio_s && !cpu_turn;

	assign addressed = (instr.field == my_select);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			prio_out <= 1'b0;
		else
			prio_out <= prio_s && (slot_bypass || !want_bus);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			cpu_grant <= 1'b0;
		else
			cpu_grant <= cpu_req_s && (!won_bus || cpu_turn);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			starve_r <= '0;
		else if (!cpu_req_s || cpu_grant)
			starve_r <= '0;
		else if (starve_r != 8'hFF)
			starve_r <= starve_r + 8'h01;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			selected_r <= 1'b0;
		else if (instr_strobe && instr_kind == io_master_pkg::IOI_ADDRESS)
			selected_r <= addressed;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			instr_accept <= 1'b0;
			card_field   <= `SELECT_RESET;
		end else begin
			instr_accept <= instr_strobe && instr_kind == io_master_pkg::IOI_TRANSFER &&
			                (auto_mode ? selected_r : addressed);
			if (instr_strobe && auto_mode && selected_r &&
			    instr_kind == io_master_pkg::IOI_TRANSFER)
				card_field <= instr.field;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r   <= ST_IDLE;
			addr_r    <= '0;
			count_r   <= '0;
			last_r    <= 1'b0;
			chain_irq <= 1'b0;
		end else begin
			chain_irq <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (desc_in.valid && desc_in.count != '0) begin
						addr_r  <= desc_in.addr;
						count_r <= desc_in.count;
						last_r  <= desc_last;
						state_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (eot_s) begin
						state_r <= ST_DONE;
					end else if (won_bus) begin
						addr_r  <= addr_r + 1'b1;
						count_r <= count_r - 1'b1;
						if (count_r == 16'h0001)
							state_r <= last_r ? ST_DONE : ST_IDLE;
					end
				end
				ST_DONE: begin
					chain_irq <= 1'b1;
					state_r   <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mem_req   <= 1'b0;
			mem_addr  <= '0;
			mem_wdata <= '0;
			mem_write <= 1'b0;
		end else begin
			mem_req   <= won_bus;
			mem_write <= won_bus;
			if (won_bus) begin
				mem_addr  <= addr_r;
				mem_wdata <= fifo_data;
			end
		end
	end

endmodule : io_master

// [test/io_master_chk.sv]
// Purpose: Port checker for io_master
// Assumes: Synced inputs lag two cycles
// Notes:   Bind follows the module
`timescale 1ns/10ps
module io_master_chk #(
	parameter int STARVE = 33
) (
	input wire logic                           mclk,
	input wire logic                           rst_n,
	input wire logic [5:0]                     my_select,
	input wire logic                           auto_mode,
	input wire logic                           slot_bypass,
	input wire io_master_pkg::io_instr_type    instr,
	input wire io_master_pkg::io_kind_type     instr_kind,
	input wire logic                           instr_strobe,
	input wire logic                           instr_accept,
	input wire logic [5:0]                     card_field,
	input wire logic                           prio_in,
	input wire logic                           prio_out,
	input wire logic                           cpu_req,
	input wire logic                           cpu_grant,
	input wire logic                           mem_req,
	input wire logic                           chain_irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	int unsigned wait_r;
	// Slack covers input sync and output flop
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) wait_r <= 0;
		else wait_r <= (cpu_req && !cpu_grant) ? wait_r + 1 : 0;
	end
	property p_irq; chain_irq |=> !chain_irq; endproperty
	a_irq: assert property (p_irq) else $error("chain irq too long");
	// Request flop lags the strap by one cycle
	property p_quiet; slot_bypass |=> !mem_req; endproperty
	a_quiet: assert property (p_quiet) else $error("bypass card requested");
	property p_pass; (slot_bypass && prio_in) [*4] |-> prio_out; endproperty
	a_pass: assert property (p_pass) else $error("bypass lost grant");
	property p_starve; wait_r <= STARVE + 3; endproperty
	a_starve: assert property (p_starve) else $error("cpu starved");
	property p_idle; !cpu_req [*5] |-> !cpu_grant; endproperty
	a_idle: assert property (p_idle) else $error("grant without request");
	property p_miss;
		instr_strobe && instr_kind == io_master_pkg::IOI_TRANSFER && !auto_mode
			&& instr.field != my_select |=> !instr_accept;
	endproperty
	a_miss: assert property (p_miss) else $error("accepted foreign code");
	property p_hit;
		instr_strobe && instr_kind == io_master_pkg::IOI_TRANSFER && !auto_mode
			&& instr.field == my_select |=> instr_accept;
	endproperty
	a_hit: assert property (p_hit) else $error("own code refused");
	property p_field; instr_accept && auto_mode |-> card_field == $past(instr.field); endproperty
	a_field: assert property (p_field) else $error("freed bits wrong");
	c_irq: cover property (chain_irq);
	c_gnt: cover property (cpu_req && cpu_grant);
	c_auto: cover property (instr_accept && auto_mode);
endmodule : io_master_chk
bind io_master io_master_chk #(.STARVE(STARVE)) chk (.*);

// [test/mem_model.sv]
// Purpose: Shared memory seen by the card
// Assumes: Card only writes
// Notes:   Always ready, keeps last word
`timescale 1ns/10ps
module mem_model (
	input wire logic        mclk,
	input wire logic        mem_req,
	input wire logic        mem_write,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata
);
	int          n_wr = 0;
	logic [15:0] last_a;
	logic [15:0] last_d;
	always @(posedge mclk) begin
		if (mem_req && mem_write) begin
			n_wr++;
			last_a = mem_addr;
			last_d = mem_wdata;
		end
	end
endmodule : mem_model

// [test/testbench.sv]
// Purpose: Self-checking bench for io_master
// Assumes: Card writes device words to memory
// Notes:   Small FIFO-sized bursts keep run short
`timescale 1ns/10ps
module testbench;
	logic mclk = 0, rst_n = 0, auto_mode = 0, slot_bypass = 0, instr_strobe = 0;
	logic desc_last = 0, eot_in = 0, dev_valid = 0, prio_in = 0, cpu_req = 0;
	logic [5:0] card_field, my_select = 6'h15;
	logic [15:0] dev_data = 16'h0, mem_addr, mem_wdata;
	logic instr_accept, dev_ready, prio_out, cpu_grant, mem_req, mem_write, chain_irq;
	io_master_pkg::io_instr_type instr = '0;
	io_master_pkg::io_kind_type instr_kind = io_master_pkg::IOI_NONE;
	io_master_pkg::dma_desc_type desc_in = '0;
	int n_mismatch = 0, samples_checked = 0, cycles = 0, n_irq = 0, n_gnt = 0;
	io_master uut (.*);
	mem_model mm (.*);
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		n_irq += chain_irq;
		n_gnt += cpu_grant;
		if (cycles == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test
	task chk(string nm, logic [15:0] e, logic [15:0] g);
		samples_checked++;
		if (e !== g) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task ins(io_master_pkg::io_kind_type k, logic [5:0] f, logic e);
		@(posedge mclk) {instr, instr_kind, instr_strobe} <= {10'h000, f, k, 1'b1};
		@(posedge mclk) instr_strobe <= 0;
		#1 chk("accept", e, instr_accept);
	endtask : ins
	task desc(logic [15:0] n, logic l);
		@(posedge mclk) {desc_in, desc_last} <= {1'b1, 16'h0100, n, l};
		@(posedge mclk) desc_in <= '0;
	endtask : desc
	task push(int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk) {dev_data, dev_valid} <= {16'hA000 + i[15:0], 1'b1};
		end
		@(posedge mclk) dev_valid <= 0;
	endtask : push
	task t_sel();
		ins(io_master_pkg::IOI_TRANSFER, 6'h15, 1);
		ins(io_master_pkg::IOI_TRANSFER, 6'h16, 0);
		auto_mode <= 1;
		ins(io_master_pkg::IOI_ADDRESS, 6'h15, 0);
		ins(io_master_pkg::IOI_TRANSFER, 6'h2A, 1);
		chk("field", 16'h002A, {10'h000, card_field});
		ins(io_master_pkg::IOI_ADDRESS, 6'h01, 0);
		ins(io_master_pkg::IOI_TRANSFER, 6'h15, 0);
		auto_mode <= 0;
		$display("t_sel done");
	endtask : t_sel
	task t_dma();
		push(32);
		#1 chk("full", 0, dev_ready);
		cpu_req <= 1;
		{n_irq, n_gnt, prio_in} = {32'd0, 32'd0, 1'b1};
		desc(40, 1);
		// Refill keeps the card on the bus past the fairness limit
		push(8);
		n_gnt = 0;
		repeat (30) @(posedge mclk);
		chk("gnt", 1, n_gnt > 0);
		repeat (90) @(posedge mclk);
		chk("words", 40, mm.n_wr[15:0]);
		chk("addr", 16'h0127, mm.last_a);
		chk("data", 16'hA007, mm.last_d);
		chk("irq", 1, n_irq[15:0]);
		$display("t_dma done");
	endtask : t_dma
	task t_chain();
		n_irq = 0;
		push(3);
		desc(2, 0);
		repeat (20) @(posedge mclk);
		chk("mid", 0, n_irq[15:0]);
		desc(1, 1);
		repeat (20) @(posedge mclk);
		chk("end", 1, n_irq[15:0]);
		push(1);
		desc(8, 1);
		repeat (20) @(posedge mclk) eot_in <= 1;
		@(posedge mclk) eot_in <= 0;
		repeat (10) @(posedge mclk);
		chk("eot", 2, n_irq[15:0]);
		$display("t_chain done");
	endtask : t_chain
	task t_bypass();
		{slot_bypass, cpu_req} <= 2'b10;
		repeat (6) @(posedge mclk);
		#1 chk("pass", 1, prio_out);
		@(posedge mclk) prio_in <= 0;
		repeat (5) @(posedge mclk);
		#1 chk("gnt", 0, cpu_grant);
		chk("stop", 0, prio_out);
		$display("t_bypass done");
	endtask : t_bypass
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1;
		repeat (3) @(posedge mclk);
		t_sel();
		t_dma();
		t_chain();
		t_bypass();
		end_of_test();
	end
endmodule : testbench
